// ===== hw/wsbs_top.sv
// wait-state generator and bank-switch timing with Avalon-MM registers
//
// Behaviour
// - extended select picks program wait ranges
// - bits 14-12 give I/O waits
// - bits 11-9 give upper data waits
// - bits 8-6 give lower data waits
// - bits 5-3 give upper program waits
// - bits 2-0 give lower program waits
// - multiplier bit doubles counts, resets zero
// - multiplier register upper bits read zero
// - one idle cycle when a read crosses banks
// - consecutive mode: non-I/O reads add an idle cycle, all reads a trailing cycle
// - output clock divides by field plus one, by two when the field is zero
// - ack-off bit set at reset, gates ack
// - host keeper on by bit or strap
// - data keeper follows its bit
// - remember top bit, withhold a read's strobe on change
// - same bank read has no idle
// - idle on program/data space change or program page change between reads
// - ready input extends beyond software waits
// - wait counter idles when all zero
//
// The Avalon-MM slave port was left to the implementer.
`include "wsbs_params.svh"
`default_nettype none
module wsbs_top (
    input  wire logic              clock,          // 50 MHz system clock
    input  wire logic              reset_n,        // async reset, active low
    input  wire logic [7:0]        avs_address,    // word index
    input  wire logic              avs_read,       // read request
    input  wire logic              avs_write,      // write request
    input  wire logic [31:0]       avs_writedata,  // write data
    output logic [31:0]            avs_readdata,   // read data
    output logic                   avs_waitrequest,// stall
    input  wire wsbs_pkg::wsbs_req_s acc_req,      // access request, held until done
    input  wire logic              ext_ready,      // external ready pin
    input  wire logic              wide_host_port_strap, // strap pin
    input  wire logic              ack_request,    // core acknowledge event
    output wsbs_pkg::wsbs_ext_s    ext_ctl,        // strobe, done, keepers
    output logic                   output_clock,   // divided clock
    output logic                   interrupt_acknowledge_out, // ack pin
    output logic                   wait_clock_gate // wait counter clock enabled
);
    import wsbs_pkg::*;

    logic [15:0] wait_fields_q;
    logic [15:0] bank_ctrl_q;
    logic        mult_q;
    logic [31:0] rdata_d;
    logic        hit_w;
    logic        hit_b;
    logic        hit_m;

    assign hit_w = (avs_address == `WSBS_IDX_WAIT_FIELDS);
    assign hit_b = (avs_address == `WSBS_IDX_BANK_CTRL);
    assign hit_m = (avs_address == `WSBS_IDX_MULT_CTRL);

    // register writes; unmapped writes are dropped
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wait_fields_q <= `WSBS_WAIT_RESET;
            bank_ctrl_q   <= `WSBS_BANK_RESET;
            mult_q        <= 1'b0;
        end else if (avs_write && !avs_waitrequest) begin
            if (hit_w) wait_fields_q <= avs_writedata[15:0];
            if (hit_b) bank_ctrl_q <= avs_writedata[15:0] & `WSBS_BANK_WMASK;
            if (hit_m) mult_q <= avs_writedata[`WSBS_BIT_MULT];
        end
    end

    // read mux; unmapped reads answer zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_w) rdata_d = {16'h0000, wait_fields_q};
        if (hit_b) rdata_d = {16'h0000, bank_ctrl_q};
        if (hit_m) rdata_d = {31'h0000_0000, mult_q};
    end

    // one wait cycle per request so readdata comes from a flop
    // waitrequest is a flop too: high while idle, low for exactly one cycle
    // in the second cycle of a request, so a held request is not taken twice
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            avs_readdata    <= rdata_d;
        end
    end

    // range select for the access
    logic       xprog;
    logic [2:0] base_w;
    logic [3:0] waits_w;
    assign xprog = wait_fields_q[`WSBS_BIT_XPROG];
    always_comb begin
        base_w = wait_fields_q[`WSBS_LSB_IO +: 3];
        case (acc_req.space)
            WSBS_SP_DATA: base_w = acc_req.addr[15] ?
                wait_fields_q[`WSBS_LSB_DHI +: 3] :
                wait_fields_q[`WSBS_LSB_DLO +: 3];
            WSBS_SP_PROG: base_w = (xprog ? acc_req.addr[22] : acc_req.addr[15]) ?
                wait_fields_q[`WSBS_LSB_PHI +: 3] :
                wait_fields_q[`WSBS_LSB_PLO +: 3];
            default: base_w = wait_fields_q[`WSBS_LSB_IO +: 3];
        endcase
    end
    assign waits_w = mult_q ? {base_w, 1'b0} : {1'b0, base_w};

    // bank-switch decision
    logic        last_msb_q;
    logic        last_prog_q;
    logic        last_read_q;
    logic        last_valid_q;
    logic [6:0]  last_page_q;
    logic        need_idle;
    logic        cur_prog;
    logic        cur_msb;
    assign cur_prog = (acc_req.space == WSBS_SP_PROG);
    assign cur_msb  = acc_req.addr[15];
    always_comb begin
        need_idle = 1'b0;
        if (acc_req.read && acc_req.space != WSBS_SP_IO) begin
            if (bank_ctrl_q[`WSBS_BIT_CONSEC])
                need_idle = 1'b1;
            else if (last_valid_q) begin
                need_idle = (cur_msb != last_msb_q);
                if (last_read_q && cur_prog != last_prog_q)
                    need_idle = 1'b1;
                if (last_read_q && cur_prog && last_prog_q
                    && acc_req.addr[22:16] != last_page_q)
                    need_idle = 1'b1;
            end
        end
    end

    // access sequencer: idle, strobe with waits, trailing cycle
    typedef enum logic [2:0] {ST_IDLE, ST_SWITCH, ST_STROBE, ST_WAIT, ST_TRAIL, ST_DONE} st_e;
    st_e        st_q;
    logic [3:0] cnt_q;
    logic [1:0] rdy_sync_q;
    logic       strobe_q;
    logic       done_q;

    // ready pin passes two flops before use
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) rdy_sync_q <= 2'b00;
        else          rdy_sync_q <= {rdy_sync_q[0], ext_ready};
    end

    // strap pin passes two flops before the keeper logic reads it
    logic [1:0] strap_sync_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) strap_sync_q <= 2'b00;
        else          strap_sync_q <= {strap_sync_q[0], wide_host_port_strap};
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            strobe_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                ST_IDLE: if (acc_req.valid) begin
                    cnt_q <= waits_w;
                    if (need_idle) begin
                        st_q <= ST_SWITCH;
                    end else begin
                        st_q <= ST_STROBE;
                        strobe_q <= 1'b1;
                    end
                end
                ST_SWITCH: begin
                    st_q <= ST_STROBE;
                    strobe_q <= 1'b1;
                end
                ST_STROBE, ST_WAIT: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                        st_q <= ST_WAIT;
                    end else if (rdy_sync_q[1]) begin
                        strobe_q <= 1'b0;
                        if (bank_ctrl_q[`WSBS_BIT_CONSEC] && acc_req.read) begin
                            st_q <= ST_TRAIL;
                        end else begin
                            st_q <= ST_DONE;
                            done_q <= 1'b1;
                        end
                    end
                end
                ST_TRAIL: begin
                    st_q <= ST_DONE;
                    done_q <= 1'b1;
                end
                // wait for valid to drop: the requester sees done a cycle late
                // and would otherwise have its held request taken again
                ST_DONE: begin
                    if (!acc_req.valid) st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // last-access memory, updated at access start
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last_msb_q <= 1'b0;
            last_prog_q <= 1'b0;
            last_read_q <= 1'b0;
            last_valid_q <= 1'b0;
            last_page_q <= 7'h00;
        end else if (st_q == ST_IDLE && acc_req.valid
                     && acc_req.space != WSBS_SP_IO) begin
            last_msb_q <= cur_msb;
            last_prog_q <= cur_prog;
            last_read_q <= acc_req.read;
            last_valid_q <= 1'b1;
            last_page_q <= acc_req.addr[22:16];
        end
    end

    // output clock divider
    logic [1:0] div_cnt_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_q <= 2'b00;
            output_clock <= 1'b0;
        end else if (div_cnt_q >= bank_ctrl_q[`WSBS_LSB_DIV +: 2]) begin
            div_cnt_q <= 2'b00;
            output_clock <= (bank_ctrl_q[`WSBS_LSB_DIV +: 2] == 2'b00) ? ~output_clock : 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 2'b01;
            output_clock <= (div_cnt_q + 2'b01) < {1'b0, bank_ctrl_q[`WSBS_LSB_DIV + 1]} + 2'b01
                ? 1'b1 : 1'b0;
        end
    end

    // keepers, acknowledge output and wait clock gate
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ext_ctl <= '0;
            interrupt_acknowledge_out <= 1'b1;
            wait_clock_gate <= 1'b1;
        end else begin
            ext_ctl.strobe <= strobe_q;
            ext_ctl.done <= done_q;
            ext_ctl.data_keep <= bank_ctrl_q[`WSBS_BIT_DKEEP];
            ext_ctl.host_keep <= bank_ctrl_q[`WSBS_BIT_HKEEP] | strap_sync_q[1];
            ext_ctl.addr_keep <= bank_ctrl_q[`WSBS_BIT_DKEEP] & strap_sync_q[1];
            // with ack-off enabled the ack pin stays high (inactive)
            interrupt_acknowledge_out <= bank_ctrl_q[`WSBS_BIT_ACKOFF] | ~ack_request;
            // the counter only needs clocks when some range has waits
            wait_clock_gate <= (wait_fields_q[14:0] != 15'h0000);
        end
    end

    // the strobe is low during the inserted idle cycle
    AST_IDLE_NO_STROBE: assert property (@(posedge clock) disable iff (!reset_n)
        st_q == ST_SWITCH |-> !strobe_q) else $error("strobe during idle cycle");
    // doubled count loaded when multiplier set
    AST_MULT_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == ST_IDLE && acc_req.valid && mult_q) |=> cnt_q[0] == 1'b0)
        else $error("odd count with multiplier");
    AST_MULT_READ: assert property (@(posedge clock) disable iff (!reset_n)
        (hit_m && avs_read && !avs_waitrequest) |-> avs_readdata[31:1] == 31'h0)
        else $error("multiplier upper bits not zero");
    AST_CONSEC_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == ST_IDLE && acc_req.valid && acc_req.read && cur_prog
         && bank_ctrl_q[`WSBS_BIT_CONSEC]) |=> st_q == ST_SWITCH)
        else $error("no start cycle in consecutive mode");
    AST_SAME_BANK: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == ST_IDLE && acc_req.valid && !bank_ctrl_q[`WSBS_BIT_CONSEC]
         && last_valid_q && acc_req.space == WSBS_SP_DATA && last_read_q
         && !last_prog_q && cur_msb == last_msb_q) |=> st_q == ST_STROBE)
        else $error("idle inserted on same bank");
    AST_BANK_CROSS: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == ST_IDLE && acc_req.valid && acc_req.read && last_valid_q
         && acc_req.space != WSBS_SP_IO && cur_msb != last_msb_q) |=> st_q == ST_SWITCH)
        else $error("missing idle on bank cross");
    AST_WAIT_COUNT: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == ST_WAIT && cnt_q != 4'h0) |=> cnt_q == $past(cnt_q) - 4'h1)
        else $error("wait counter not counting");
    AST_READY_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
        (strobe_q && cnt_q == 4'h0 && !rdy_sync_q[1]) |=> strobe_q)
        else $error("strobe ended without ready");
    AST_HKEEP: assert property (@(posedge clock) disable iff (!reset_n)
        bank_ctrl_q[`WSBS_BIT_HKEEP] |=> ext_ctl.host_keep)
        else $error("host keeper off");
    // the strap alone turns the host keeper on
    AST_HOST_STRAP: assert property (@(posedge clock) disable iff (!reset_n)
        strap_sync_q[1] |=> ext_ctl.host_keep)
        else $error("host keeper off with strap");
    // data keeper follows its bit both ways
    AST_DKEEP_ON: assert property (@(posedge clock) disable iff (!reset_n)
        bank_ctrl_q[`WSBS_BIT_DKEEP] |=> ext_ctl.data_keep)
        else $error("data keeper off");
    AST_DKEEP_OFF: assert property (@(posedge clock) disable iff (!reset_n)
        !bank_ctrl_q[`WSBS_BIT_DKEEP] |=> !ext_ctl.data_keep)
        else $error("data keeper on");
    // ack-off keeps the pin inactive, otherwise the pin follows the event
    AST_ACKOFF: assert property (@(posedge clock) disable iff (!reset_n)
        bank_ctrl_q[`WSBS_BIT_ACKOFF] |=> interrupt_acknowledge_out)
        else $error("ack pin driven with ack-off");
    AST_ACK_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
        (!bank_ctrl_q[`WSBS_BIT_ACKOFF] && ack_request) |=> !interrupt_acknowledge_out)
        else $error("ack pin not driven");
    // the wait counter clock stops only when every range has zero waits
    AST_GATE_OFF: assert property (@(posedge clock) disable iff (!reset_n)
        (wait_fields_q[14:0] == 15'h0000) |=> !wait_clock_gate)
        else $error("wait clock not gated");
    AST_GATE_ON: assert property (@(posedge clock) disable iff (!reset_n)
        (wait_fields_q[14:0] != 15'h0000) |=> wait_clock_gate)
        else $error("wait clock gated with waits set");
    // I/O space never sees a bank-switch idle cycle
    AST_IO_NO_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == ST_IDLE && acc_req.valid && acc_req.space == WSBS_SP_IO) |=> st_q == ST_STROBE)
        else $error("idle cycle on I/O access");
    // the idle cycle is followed by the strobed access
    AST_SWITCH_STROBE: assert property (@(posedge clock) disable iff (!reset_n)
        st_q == ST_SWITCH |=> (st_q == ST_STROBE && strobe_q))
        else $error("no strobe after idle cycle");
    // a consecutive-mode read ends with a trailing cycle, then done
    AST_CONSEC_TRAIL: assert property (@(posedge clock) disable iff (!reset_n)
        ((st_q == ST_STROBE || st_q == ST_WAIT) && cnt_q == 4'h0 && rdy_sync_q[1]
         && bank_ctrl_q[`WSBS_BIT_CONSEC] && acc_req.read) |=> st_q == ST_TRAIL)
        else $error("no trailing cycle");
    AST_TRAIL_DONE: assert property (@(posedge clock) disable iff (!reset_n)
        st_q == ST_TRAIL |=> done_q)
        else $error("no done after trailing cycle");
    // only bit 0 of the multiplier register takes a write
    AST_MULT_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
        (hit_m && avs_write && !avs_waitrequest) |=> mult_q == $past(avs_writedata[0]))
        else $error("multiplier write lost");
endmodule // wsbs_top
`default_nettype wire

// ===== hw/wsbs_params.svh
// offsets, field positions, reset values and write mask of the wait-state block
`ifndef WSBS_PARAMS_SVH
`define WSBS_PARAMS_SVH
`define WSBS_IDX_WAIT_FIELDS    8'h28
`define WSBS_IDX_BANK_CTRL      8'h29
`define WSBS_IDX_MULT_CTRL      8'h2B
`define WSBS_BIT_XPROG          15
`define WSBS_LSB_IO             12
`define WSBS_LSB_DHI            9
`define WSBS_LSB_DLO            6
`define WSBS_LSB_PHI            3
`define WSBS_LSB_PLO            0
`define WSBS_BIT_MULT           0
`define WSBS_BIT_CONSEC         15
`define WSBS_LSB_DIV            13
`define WSBS_BIT_ACKOFF         12
`define WSBS_BIT_HKEEP          2
`define WSBS_BIT_DKEEP          1
`define WSBS_WAIT_RESET         16'h7FFF
`define WSBS_BANK_RESET         16'hF000
`define WSBS_MULT_RESET         16'h0000
`define WSBS_BANK_WMASK         16'hF006
`endif

// ===== hw/wsbs_pkg.sv
// types shared by the wait-state and bank-switch block
`default_nettype none
package wsbs_pkg;
    typedef enum logic [1:0] {
        WSBS_SP_PROG,
        WSBS_SP_DATA,
        WSBS_SP_IO
    } wsbs_space_e;
    // one external access request from the core
    typedef struct packed {
        logic        valid;
        logic        read;
        wsbs_space_e space;
        logic [22:0] addr;
    } wsbs_req_s;
    // external strobe and keeper controls
    typedef struct packed {
        logic strobe;
        logic done;
        logic data_keep;
        logic host_keep;
        logic addr_keep;
    } wsbs_ext_s;
endpackage : wsbs_pkg
`default_nettype wire

// ===== sim/wsbs_mem_model.sv
// external memory model: answers the strobe on its ready pin
`default_nettype none
module wsbs_mem_model (
    input  wire logic                clock,   // system clock
    input  wire logic                reset_n, // async reset, active low
    input  wire wsbs_pkg::wsbs_ext_s ext_ctl, // strobe from the block
    input  wire logic                slow,    // stretch every access
    output logic                     ready    // ready pin, high = ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import wsbs_pkg::*;
    logic [3:0] held_q;
    // count strobe cycles; a slow part keeps ready low for four of them
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) held_q <= 4'h0;
        else if (!ext_ctl.strobe) held_q <= 4'h0;
        else if (held_q != 4'hF) held_q <= held_q + 4'h1;
    end
    // for a slow part, low outside the strobe too, so a stale high cannot end an access early
    assign ready = !slow || (held_q >= 4'h4);
endmodule // wsbs_mem_model
`default_nettype wire

// ===== sim/wsbs_top_tb.sv
// self-checking bench for the wait-state and bank-switch block
`default_nettype none
module wsbs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wsbs_pkg::*;
    localparam wsbs_space_e SP = WSBS_SP_PROG, SD = WSBS_SP_DATA, SI = WSBS_SP_IO;
    logic clock = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic avs_waitrequest, ext_ready, strap = 1'b0, ack_request = 1'b0, slow = 1'b0;
    logic output_clock, ack_out, wait_clock_gate;
    wsbs_req_s acc_req = '0;
    wsbs_ext_s ext_ctl;
    int fail_count = 0, num_checks = 0, n, t[3], nr;
    logic prev;
    always #10 clock = ~clock;
    wsbs_top dut_u (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_req(acc_req),
        .ext_ready(ext_ready), .wide_host_port_strap(strap), .ack_request(ack_request),
        .ext_ctl(ext_ctl), .output_clock(output_clock),
        .interrupt_acknowledge_out(ack_out), .wait_clock_gate(wait_clock_gate));
    wsbs_mem_model mem_u (.clock(clock), .reset_n(reset_n), .ext_ctl(ext_ctl),
        .slow(slow), .ready(ext_ready));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one Avalon transfer; request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        int k;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= !w;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata[15:0];
        if (avs_waitrequest !== 1'b0) fail_count++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, q);
        check("register read", {16'h0000, q}, {16'h0000, e});
    endtask
    // cycles from raising valid until done is seen; valid drops on the next edge
    task automatic acc(input wsbs_space_e s, input logic [22:0] a, input logic r, input int e);
        @(posedge clock);
        acc_req <= '{valid: 1'b1, read: r, space: s, addr: a};
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (ext_ctl.done !== 1'b1 && n < 100);
        @(posedge clock);
        acc_req.valid <= 1'b0;
        if (e > 0) check("access cycles", n, e);
    endtask
    task automatic ack_pulse(input logic e);
        @(posedge clock);
        ack_request <= 1'b1;
        prev = 1'b1;
        repeat (4) begin
            @(posedge clock);
            ack_request <= 1'b0;
            #1;
            if (ack_out === 1'b0) prev = 1'b0;
        end
        check("ack pin high", prev, e);
    endtask
    initial begin
        #(20 * 20000);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        rd(8'h28, 16'h7FFF);
        rd(8'h29, 16'hF000);
        rd(8'h2B, 16'h0000);
        wr(8'h2B, 16'hFFFF);
        rd(8'h2B, 16'h0001);
        wr(8'h2B, 16'h0000);
        wr(8'h29, 16'hFFFF);
        rd(8'h29, 16'hF006);
        wr(8'h30, 16'hFFFF);
        rd(8'h30, 16'h0000);
        $display("test registers done");
        // fields: io 1, data high 2, data low 3, program high 4, program low 5
        wr(8'h28, 16'h14E5);
        wr(8'h29, 16'hF000);
        acc(SD, 23'h00_0010, 1'b1, 8);
        wr(8'h29, 16'h7000);
        acc(SD, 23'h00_0020, 1'b1, 6);
        acc(SD, 23'h00_8000, 1'b1, 6);
        acc(SD, 23'h00_0000, 1'b0, 6);
        acc(SD, 23'h00_0001, 1'b1, 6);
        acc(SP, 23'h00_0100, 1'b1, 9);
        acc(SP, 23'h00_8100, 1'b1, 8);
        acc(SP, 23'h01_8100, 1'b1, 8);
        acc(SI, 23'h00_0000, 1'b1, 4);
        acc(SP, 23'h01_8200, 1'b1, 7);
        wr(8'h28, 16'h94E5);
        acc(SP, 23'h40_8200, 1'b1, 8);
        acc(SP, 23'h00_8200, 1'b1, 9);
        wr(8'h2B, 16'h0001);
        acc(SI, 23'h00_0000, 1'b1, 5);
        wr(8'h29, 16'hF000);
        acc(SD, 23'h00_0000, 1'b1, 11);
        acc(SD, 23'h00_0000, 1'b0, 9);
        slow <= 1'b1;
        acc(SI, 23'h00_0000, 1'b1, 0);
        check("ready stretches", n > 5, 1'b1);
        slow <= 1'b0;
        wr(8'h2B, 16'h0000);
        $display("test access timing done");
        wr(8'h28, 16'h0000);
        repeat (3) @(posedge clock);
        check("wait clock gate", wait_clock_gate, 1'b0);
        wr(8'h28, 16'h0008);
        repeat (3) @(posedge clock);
        check("wait clock gate", wait_clock_gate, 1'b1);
        // the period from the first rise after a write to the second may be off, so time the next one
        for (int k = 1; k < 4; k++) begin
            wr(8'h29, 16'h1000 | 16'(k << 13));
            nr = 0;
            prev = output_clock;
            for (int c = 0; c < 30 && nr < 3; c++) begin
                @(posedge clock);
                #1;
                if (output_clock === 1'b1 && prev === 1'b0) t[nr++] = c;
                prev = output_clock;
            end
            check("clock period", t[2] - t[1], k + 1);
        end
        ack_pulse(1'b1);
        wr(8'h29, 16'h6000);
        ack_pulse(1'b0);
        for (int m = 0; m < 8; m++) begin
            strap <= m[2];
            wr(8'h29, 16'h7000 | 16'(m[1:0] << 1));
            repeat (2) @(posedge clock);
            check("keepers", {ext_ctl.data_keep, ext_ctl.host_keep, ext_ctl.addr_keep},
                  {m[0], m[1] | m[2], m[0] & m[2]});
        end
        $display("test controls done");
        complete_run();
    end
endmodule // wsbs_top_tb
`default_nettype wire
